/* rtl/rfc_cmd_engine.v */
// Ring format and statistics counter command engine
//
// Behaviour
// - Word 0 low byte is opcode, high byte zero; 10 reads, 11 loads ring.
// - Opcode 11 fetches ring parameters from host and adopts them.
// - Opcode 10 writes held ring parameters to host in load layout.
// - Data block base: bits 15:1 from word 1, bits 17:16 from word 2.
// - Word 2 upper byte ignored; host keeps bits 7:2 zero.
// - Block words 0,2,4: tx base, entry size and base high, count.
// - Block words 6,10,12 octal: receive base, size and high, count.
// - Opcode 12 dumps counters; opcode 13 dumps then clears them.
// - Clearing happens only after the last word reached host memory.
// - Device never writes the command block.
// - Word 3 bits 15:1 give list length, capped at 55; prefix only.
// - Counters are unsigned and stick at all ones.
// - List word 0 is block length, word 1 seconds since cleared.
// - Octal 4/6 hold 32-bit good receive frames, low half first.
// - Octal 10/12 hold 32-bit good multicast receive frames.
// - List holds 32-bit two-attempt and deferred transmit frame counts.
// - Octal 60/62 transmit bytes, 64/66 multicast transmit bytes.
// - Octal 70 abort cause bitmap, 72 aborted transmit frames.
// - Octal 74 collision check, 100 driver errors, 102 babble.
`timescale 1ns/1ps
`include "rfc_consts.vh"

module rfc_sat_ctr #(
   parameter W  = 32,
   parameter IW = 1
) (
   input  wire          ref_clk,
   input  wire          rst,
   input  wire          clr,
   input  wire [IW-1:0] inc,
   output reg  [W-1:0]  q
);
   // A clear still keeps an event of the same cycle
   wire [W-1:0] base = clr ? {W{1'b0}} : q;
   wire [W:0]   sum  = {1'b0, base} + {{(W+1-IW){1'b0}}, inc};
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         q <= {W{1'b0}};
      else
         q <= sum[W] ? {W{1'b1}} : sum[W-1:0];
   end
endmodule // rfc_sat_ctr

module rfc_cmd_engine #(
   parameter SEC_CYCLES = `RFC_SEC_CYCLES
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [1:0]  regAddr,
   input  wire [15:0] regWdata,
   input  wire        regWe,
   input  wire        regRe,
   output reg  [15:0] regRdata,
   output reg         memReq,
   output reg         memWe,
   output reg  [17:0] memAddr,
   output reg  [15:0] memWdata,
   input  wire [15:0] memRdata,
   input  wire        memAck,
   output reg         cmdDone,
   output wire [17:0] txRingBase,
   output reg  [7:0]  txEntryWords,
   output reg  [15:0] txEntryCount,
   output wire [17:0] rxRingBase,
   output reg  [7:0]  rxEntryWords,
   output reg  [15:0] rxEntryCount,
   input  wire        evRxFrame,
   input  wire        evRxMcast,
   input  wire        evTx2Att,
   input  wire        evTxDefer,
   input  wire        evTxBytes,
   input  wire        evTxMcBytes,
   input  wire [15:0] txByteCount,
   input  wire        evTxAbort,
   input  wire [5:0]  txAbortCause,
   input  wire        evCollFail,
   input  wire        evDrvErr,
   input  wire        evBabble
);
   localparam S_IDLE  = 3'h0;
   localparam S_CMD   = 3'h1;
   localparam S_SETUP = 3'h2;
   localparam S_XFER  = 3'h3;
   localparam S_CLEAR = 3'h4;
   localparam S_DONE  = 3'h5;

   reg  [2:0]  state_reg;
   reg  [1:0]  cmdIdx_reg;
   reg  [5:0]  idx_reg;
   reg  [5:0]  len_reg;
   reg  [15:0] cmdBaseLo_reg;
   reg  [1:0]  cmdBaseHi_reg;
   reg  [7:0]  opcode_reg;
   reg  [15:0] baseLo_reg;
   reg  [1:0]  baseHi_reg;
   reg  [14:0] counter_list_words_reg;
   reg         err_reg;
   reg  [16:0] txBase_reg;
   reg  [16:0] rxBase_reg;
   reg  [5:0]  abortMap_reg;
   reg  [31:0] secDiv_reg;
   reg  [15:0] listWord;
   reg  [5:0]  lenCalc;

   wire        isRing  = opcode_reg == `RFC_OP_RING_RD ||
                         opcode_reg == `RFC_OP_RING_WR;
   wire        isCtr   = opcode_reg == `RFC_OP_CTR_RD ||
                         opcode_reg == `RFC_OP_CTR_CLR;
   wire        ctrClr  = state_reg == S_CLEAR;
   wire        secTick = secDiv_reg == SEC_CYCLES - 1;
   wire        badCmd  = state_reg == S_CMD && memAck &&
                         cmdIdx_reg == `RFC_IDX_OPCODE &&
                         (memRdata[15:8] != 8'h00 ||
                          memRdata[7:0] < `RFC_OP_RING_RD ||
                          memRdata[7:0] > `RFC_OP_CTR_CLR);
   wire        lastXfer = idx_reg == len_reg - 6'h01;
   wire [5:0]  wordIdx  = (state_reg == S_SETUP) ? 6'h00 :
                          idx_reg + 6'h01;
   wire [17:0] dbBase   = {baseHi_reg, baseLo_reg[15:1], 1'b0};
   wire [15:0] secs, abortCnt, collCnt, drvCnt, babCnt;
   wire [31:0] rxFrm, rxMc, tx2, txDef, txByt, txMcByt;

   assign txRingBase = {txBase_reg, 1'b0};
   assign rxRingBase = {rxBase_reg, 1'b0};

   // Seconds prescaler restarts with every clear of the counters
   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         secDiv_reg <= 32'h00000000;
      else if (ctrClr || secTick)
         secDiv_reg <= 32'h00000000;
      else
         secDiv_reg <= secDiv_reg + 32'h00000001;
   end

   rfc_sat_ctr #(.W(16), .IW(1)) uSecs (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(secTick), .q(secs));
   rfc_sat_ctr #(.W(32), .IW(1)) uRxFrm (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evRxFrame), .q(rxFrm));
   rfc_sat_ctr #(.W(32), .IW(1)) uRxMc (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evRxMcast), .q(rxMc));
   rfc_sat_ctr #(.W(32), .IW(1)) uTx2 (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evTx2Att), .q(tx2));
   rfc_sat_ctr #(.W(32), .IW(1)) uTxDef (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evTxDefer), .q(txDef));
   rfc_sat_ctr #(.W(32), .IW(16)) uTxByt (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evTxBytes ? txByteCount : 16'h0000),
      .q(txByt));
   rfc_sat_ctr #(.W(32), .IW(16)) uTxMc (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evTxMcBytes ? txByteCount : 16'h0000),
      .q(txMcByt));
   rfc_sat_ctr #(.W(16), .IW(1)) uAbort (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evTxAbort), .q(abortCnt));
   rfc_sat_ctr #(.W(16), .IW(1)) uColl (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evCollFail), .q(collCnt));
   // A rejected command block also counts as a driver error
   rfc_sat_ctr #(.W(16), .IW(1)) uDrv (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evDrvErr | badCmd), .q(drvCnt));
   rfc_sat_ctr #(.W(16), .IW(1)) uBab (.ref_clk(ref_clk), .rst(rst),
      .clr(ctrClr), .inc(evBabble), .q(babCnt));

   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         abortMap_reg <= 6'h00;
      else if (ctrClr)
         abortMap_reg <= evTxAbort ? txAbortCause : 6'h00;
      else if (evTxAbort)
         abortMap_reg <= abortMap_reg | txAbortCause;
   end

   // Outgoing block word, ring layout or counter list
   always @* begin
      listWord = 16'h0000;
      if (isRing) begin
         case (wordIdx)
            6'h00: listWord = {txBase_reg[14:0], 1'b0};
            6'h01: listWord = {txEntryWords, 6'h00, txBase_reg[16:15]};
            6'h02: listWord = txEntryCount;
            6'h03: listWord = {rxBase_reg[14:0], 1'b0};
            6'h04: listWord = {rxEntryWords, 6'h00, rxBase_reg[16:15]};
            6'h05: listWord = rxEntryCount;
            default: listWord = 16'h0000;
         endcase
      end else begin
         case (wordIdx)
            `RFC_W_LEN:    listWord = {10'h000, lenCalc};
            `RFC_W_SECS:   listWord = secs;
            `RFC_W_RXF_LO: listWord = rxFrm[15:0];
            `RFC_W_RXF_HI: listWord = rxFrm[31:16];
            `RFC_W_RXM_LO: listWord = rxMc[15:0];
            `RFC_W_RXM_HI: listWord = rxMc[31:16];
            `RFC_W_TX2_LO: listWord = tx2[15:0];
            `RFC_W_TX2_HI: listWord = tx2[31:16];
            `RFC_W_DEF_LO: listWord = txDef[15:0];
            `RFC_W_DEF_HI: listWord = txDef[31:16];
            `RFC_W_TXB_LO: listWord = txByt[15:0];
            `RFC_W_TXB_HI: listWord = txByt[31:16];
            `RFC_W_TXM_LO: listWord = txMcByt[15:0];
            `RFC_W_TXM_HI: listWord = txMcByt[31:16];
            `RFC_W_ABMAP:  listWord = {10'h000, abortMap_reg};
            `RFC_W_ABCNT:  listWord = abortCnt;
            `RFC_W_COLL:   listWord = collCnt;
            `RFC_W_DRV:    listWord = drvCnt;
            `RFC_W_BABL:   listWord = babCnt;
            default:       listWord = 16'h0000;
         endcase
      end
   end

   // Counter list length, capped so a long request still ends at 55
   always @* begin
      if (isRing)
         lenCalc = `RFC_RING_WORDS;
      else if (counter_list_words_reg > {9'h000, `RFC_CTR_MAX})
         lenCalc = `RFC_CTR_MAX;
      else
         lenCalc = counter_list_words_reg[5:0];
   end

   // Register port
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         regRdata      <= 16'h0000;
         cmdBaseLo_reg <= 16'h0000;
         cmdBaseHi_reg <= 2'h0;
      end else begin
         if (regWe && regAddr == `RFC_REG_BASE_LO)
            cmdBaseLo_reg <= {regWdata[15:1], 1'b0};
         if (regWe && regAddr == `RFC_REG_BASE_HI)
            cmdBaseHi_reg <= regWdata[1:0];
         regRdata <= 16'h0000;
         if (regRe) begin
            case (regAddr)
               `RFC_REG_BASE_LO: regRdata <= cmdBaseLo_reg;
               `RFC_REG_BASE_HI: regRdata <= {14'h0000, cmdBaseHi_reg};
               `RFC_REG_CTRL:    regRdata <= {opcode_reg, 6'h00, err_reg,
                                             state_reg != S_IDLE};
               default:          regRdata <= 16'h0000;
            endcase
         end
      end
   end

   // Command sequencer
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg    <= S_IDLE;
         cmdIdx_reg   <= 2'h0;
         idx_reg      <= 6'h00;
         len_reg      <= 6'h00;
         opcode_reg   <= 8'h00;
         baseLo_reg   <= 16'h0000;
         baseHi_reg   <= 2'h0;
         counter_list_words_reg   <= 15'h0000;
         err_reg      <= 1'b0;
         memReq       <= 1'b0;
         memWe        <= 1'b0;
         memAddr      <= 18'h00000;
         memWdata     <= 16'h0000;
         cmdDone      <= 1'b0;
         txBase_reg   <= 17'h00000;
         txEntryWords <= 8'h00;
         txEntryCount <= 16'h0000;
         rxBase_reg   <= 17'h00000;
         rxEntryWords <= 8'h00;
         rxEntryCount <= 16'h0000;
      end else begin
         cmdDone <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (regWe && regAddr == `RFC_REG_CTRL && regWdata[0]) begin
                  err_reg    <= 1'b0;
                  counter_list_words_reg <= 15'h0000;
                  cmdIdx_reg <= `RFC_IDX_OPCODE;
                  memReq     <= 1'b1;
                  memWe      <= 1'b0;
                  memAddr    <= {cmdBaseHi_reg, cmdBaseLo_reg};
                  state_reg  <= S_CMD;
               end
            end
            S_CMD: begin
               if (memAck) begin
                  cmdIdx_reg <= cmdIdx_reg + 2'h1;
                  memAddr    <= memAddr + 18'h00002;
                  case (cmdIdx_reg)
                     `RFC_IDX_OPCODE: begin
                        opcode_reg <= memRdata[7:0];
                        if (badCmd) begin
                           err_reg   <= 1'b1;
                           memReq    <= 1'b0;
                           state_reg <= S_DONE;
                        end
                     end
                     `RFC_IDX_BASE_LO: baseLo_reg <= memRdata;
                     `RFC_IDX_BASE_HI: begin
                        baseHi_reg <= memRdata[1:0];
                        if (!isCtr) begin
                           memReq    <= 1'b0;
                           state_reg <= S_SETUP;
                        end
                     end
                     default: begin
                        counter_list_words_reg <= memRdata[15:1];
                        memReq     <= 1'b0;
                        state_reg  <= S_SETUP;
                     end
                  endcase
               end
            end
            S_SETUP: begin
               idx_reg  <= 6'h00;
               len_reg  <= lenCalc;
               memAddr  <= dbBase;
               memWdata <= listWord;
               memWe    <= opcode_reg != `RFC_OP_RING_WR;
               memReq   <= lenCalc != 6'h00;
               if (lenCalc == 6'h00)
                  state_reg <= (opcode_reg == `RFC_OP_CTR_CLR) ?
                               S_CLEAR : S_DONE;
               else
                  state_reg <= S_XFER;
            end
            S_XFER: begin
               if (memAck) begin
                  if (opcode_reg == `RFC_OP_RING_WR) begin
                     case (idx_reg)
                        6'h00: txBase_reg[14:0] <= memRdata[15:1];
                        6'h01: begin
                           txEntryWords      <= memRdata[15:8];
                           txBase_reg[16:15] <= memRdata[1:0];
                        end
                        6'h02: txEntryCount <= memRdata;
                        6'h03: rxBase_reg[14:0] <= memRdata[15:1];
                        6'h04: begin
                           rxEntryWords      <= memRdata[15:8];
                           rxBase_reg[16:15] <= memRdata[1:0];
                        end
                        6'h05: rxEntryCount <= memRdata;
                        default: rxEntryCount <= rxEntryCount;
                     endcase
                  end
                  if (lastXfer) begin
                     memReq    <= 1'b0;
                     memWe     <= 1'b0;
                     state_reg <= (opcode_reg == `RFC_OP_CTR_CLR) ?
                                  S_CLEAR : S_DONE;
                  end else begin
                     idx_reg  <= idx_reg + 6'h01;
                     memAddr  <= memAddr + 18'h00002;
                     memWdata <= listWord;
                  end
               end
            end
            S_CLEAR: state_reg <= S_DONE;
            S_DONE: begin
               cmdDone   <= 1'b1;
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule // rfc_cmd_engine

/* rtl/rfc_consts.vh */
// Constants for the ring format and counter command engine
`ifndef RFC_CONSTS_VH
`define RFC_CONSTS_VH
`define RFC_OP_RING_RD   8'h08
`define RFC_OP_RING_WR   8'h09
`define RFC_OP_CTR_RD    8'h0A
`define RFC_OP_CTR_CLR   8'h0B
`define RFC_RING_WORDS   6'h06
`define RFC_CTR_MAX      6'h37
`define RFC_IDX_OPCODE   2'h0
`define RFC_IDX_BASE_LO  2'h1
`define RFC_IDX_BASE_HI  2'h2
`define RFC_IDX_COUNTER_LIST_WORDS   2'h3
`define RFC_REG_BASE_LO  2'h0
`define RFC_REG_BASE_HI  2'h1
`define RFC_REG_CTRL     2'h2
`define RFC_SEC_NS       1000000000
`define RFC_CLK_NS       5
`define RFC_SEC_CYCLES   (`RFC_SEC_NS / `RFC_CLK_NS)
`define RFC_W_LEN        6'h00
`define RFC_W_SECS       6'h01
`define RFC_W_RXF_LO     6'h02
`define RFC_W_RXF_HI     6'h03
`define RFC_W_RXM_LO     6'h04
`define RFC_W_RXM_HI     6'h05
`define RFC_W_TX2_LO     6'h14
`define RFC_W_TX2_HI     6'h15
`define RFC_W_DEF_LO     6'h16
`define RFC_W_DEF_HI     6'h17
`define RFC_W_TXB_LO     6'h18
`define RFC_W_TXB_HI     6'h19
`define RFC_W_TXM_LO     6'h1A
`define RFC_W_TXM_HI     6'h1B
`define RFC_W_ABMAP      6'h1C
`define RFC_W_ABCNT      6'h1D
`define RFC_W_COLL       6'h1E
`define RFC_W_DRV        6'h20
`define RFC_W_BABL       6'h21
`endif

/* testbench/rfc_cmd_engine_properties.sv */
// Concurrent checks on the command engine ports
`timescale 1ns/1ps

module rfc_cmd_engine_properties (
   input wire        ref_clk,
   input wire        rst,
   input wire [1:0]  regAddr,
   input wire [15:0] regWdata,
   input wire        regWe,
   input wire        memReq,
   input wire        memWe,
   input wire [17:0] memAddr,
   input wire [15:0] memWdata,
   input wire [15:0] memRdata,
   input wire        memAck,
   input wire        cmdDone,
   input wire [17:0] txRingBase,
   input wire [7:0]  txEntryWords,
   input wire [17:0] rxRingBase,
   input wire [15:0] rxEntryCount
);
   reg [17:0] cmdBase_reg;
   reg [15:0] ackData_reg;
   reg        ackRd_reg;
   // Shadow of the command base so writes into the block can be caught
   always @(posedge ref_clk or posedge rst)
      if (rst) begin
         cmdBase_reg <= 18'h00000;
         ackData_reg <= 16'h0000;
         ackRd_reg   <= 1'b0;
      end else begin
         ackData_reg <= memRdata;
         ackRd_reg   <= memAck && !memWe;
         if (regWe && regAddr == 2'h0)
            cmdBase_reg[15:0] <= {regWdata[15:1], 1'b0};
         if (regWe && regAddr == 2'h1)
            cmdBase_reg[17:16] <= regWdata[1:0];
      end

   default clocking dclk @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence wr_beat;
      memReq && memAck && memWe;
   endsequence
   sequence wr_next;
      memReq && memWe;
   endsequence

   req_hold_a: assert property (
      memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe)
         && $stable(memWdata)) else $error("request moved before ack");
   word_step_a: assert property (
      wr_beat ##1 wr_next |-> memAddr == $past(memAddr) + 18'h2)
      else $error("block words not ascending by one word");
   req_end_a: assert property (
      $fell(memReq) |-> $past(memAck)) else $error("request dropped early");
   cmd_guard_a: assert property (
      wr_next |-> memAddr < cmdBase_reg || memAddr > cmdBase_reg + 18'h6)
      else $error("write into the command block");
   tx_base_a: assert property (
      $changed(txRingBase[15:0]) |-> ackRd_reg
         && txRingBase[15:0] == {ackData_reg[15:1], 1'b0})
      else $error("transmit base not taken from fetched word");
   tx_size_a: assert property (
      $changed(txEntryWords) |-> ackRd_reg
         && txEntryWords == ackData_reg[15:8])
      else $error("transmit entry size not from upper byte");
   rx_count_a: assert property (
      $changed(rxEntryCount) |-> ackRd_reg && rxEntryCount == ackData_reg)
      else $error("receive entry count not from fetched word");
   rx_base_a: assert property (
      $changed(rxRingBase[15:0]) |-> ackRd_reg
         && rxRingBase[15:0] == {ackData_reg[15:1], 1'b0})
      else $error("receive base not taken from fetched word");
   done_last_a: assert property (
      cmdDone |-> !memReq ##1 !cmdDone) else $error("done during transfer");
endmodule // rfc_cmd_engine_properties

bind rfc_cmd_engine rfc_cmd_engine_properties u_rfc_cmd_engine_properties (
   .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
   .regWe(regWe), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
   .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
   .cmdDone(cmdDone), .txRingBase(txRingBase), .txEntryWords(txEntryWords),
   .rxRingBase(rxRingBase), .rxEntryCount(rxEntryCount));

/* testbench/rfc_host_mem.sv */
// Host memory model answering the engine's word requests
`timescale 1ns/1ps

module rfc_host_mem (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [3:0]  lat,
   input  wire        memReq,
   input  wire        memWe,
   input  wire [17:0] memAddr,
   input  wire [15:0] memWdata,
   output reg  [15:0] memRdata,
   output reg         memAck
);
   reg [15:0] mem [0:131071];
   reg [3:0]  waitCnt_reg;
   // Read data is good only in the ack cycle; it toggles elsewhere so a
   // late sample cannot match by luck
   always @(posedge ref_clk or posedge rst)
      if (rst) begin
         memAck      <= 1'b0;
         memRdata    <= 16'h0000;
         waitCnt_reg <= 4'h0;
      end else if (memReq && !memAck && waitCnt_reg >= lat) begin
         memAck      <= 1'b1;
         waitCnt_reg <= 4'h0;
         if (memWe)
            mem[memAddr[17:1]] <= memWdata;
         else
            memRdata <= mem[memAddr[17:1]];
      end else begin
         memAck   <= 1'b0;
         memRdata <= ~memRdata;
         if (memReq && !memAck)
            waitCnt_reg <= waitCnt_reg + 4'h1;
      end
endmodule // rfc_host_mem

/* testbench/testbench.sv */
// Self-checking bench for the ring format and counter command engine
`timescale 1ns/1ps
`include "rfc_consts.vh"

module testbench;
   reg         ref_clk, rst, regWe, regRe;
   reg  [1:0]  regAddr;
   reg  [15:0] regWdata, txByteCount, d;
   wire [15:0] regRdata, memWdata, memRdata, txEntryCount, rxEntryCount;
   wire        memReq, memWe, memAck, cmdDone;
   wire [17:0] memAddr, txRingBase, rxRingBase;
   wire [7:0]  txEntryWords, rxEntryWords;
   reg  [9:0]  ev;
   reg  [5:0]  txAbortCause;
   reg  [3:0]  lat;
   reg  [15:0] ex [0:54];
   integer     failures, n_checks, i;

   rfc_cmd_engine #(.SEC_CYCLES(20)) u_rfc_cmd_engine (
      .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWe(regWe), .regRe(regRe), .regRdata(regRdata), .memReq(memReq),
      .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck), .cmdDone(cmdDone),
      .txRingBase(txRingBase), .txEntryWords(txEntryWords),
      .txEntryCount(txEntryCount), .rxRingBase(rxRingBase),
      .rxEntryWords(rxEntryWords), .rxEntryCount(rxEntryCount),
      .evRxFrame(ev[0]), .evRxMcast(ev[1]), .evTx2Att(ev[2]),
      .evTxDefer(ev[3]), .evTxBytes(ev[4]), .evTxAbort(ev[5]),
      .evCollFail(ev[6]), .evDrvErr(ev[7]), .evBabble(ev[8]),
      .evTxMcBytes(ev[9]), .txByteCount(txByteCount),
      .txAbortCause(txAbortCause));
   rfc_host_mem u_rfc_host_mem (
      .ref_clk(ref_clk), .rst(rst), .lat(lat), .memReq(memReq),
      .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks=%0d failures=%0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task reg_wr(input [1:0] a, input [15:0] v);
      begin
         regAddr <= a;
         regWdata <= v;
         regWe <= 1'b1;
         @(posedge ref_clk);
         regWe <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task reg_rd(input [1:0] a);
      begin
         regAddr <= a;
         regRe <= 1'b1;
         @(posedge ref_clk);
         regRe <= 1'b0;
         #1 d = regRdata;
         @(posedge ref_clk);
      end
   endtask
   // Places the four command words, points the engine at them and waits
   task run_cmd(input [17:0] cb, input [15:0] w0, w1, w2, w3);
      begin
         u_rfc_host_mem.mem[cb[17:1]] = w0;
         u_rfc_host_mem.mem[cb[17:1] + 1] = w1;
         u_rfc_host_mem.mem[cb[17:1] + 2] = w2;
         u_rfc_host_mem.mem[cb[17:1] + 3] = w3;
         reg_wr(`RFC_REG_BASE_LO, cb[15:0]);
         reg_wr(`RFC_REG_BASE_HI, {14'h0000, cb[17:16]});
         reg_wr(`RFC_REG_CTRL, 16'h0001);
         i = 0;
         while (cmdDone !== 1'b1 && i < 4000) begin
            @(posedge ref_clk);
            #1 i = i + 1;
         end
         @(posedge ref_clk);
         if (i >= 4000) begin
            failures = failures + 1;
            wrap_up;
         end
      end
   endtask
   // Word 1 (elapsed seconds) is time dependent and skipped when s is 1
   task chk_list(input [17:0] b, input integer n, input integer s);
      for (i = 0; i < n; i = i + 1)
         if (i != s)
            chk(u_rfc_host_mem.mem[b[17:1] + i], ex[i]);
   endtask

   task t_ring;
      begin
         lat = 4'h3;
         ex[0] = 16'h2344;
         ex[1] = 16'h0601;
         ex[2] = 16'h0010;
         ex[3] = 16'h0AB0;
         ex[4] = 16'h0803;
         ex[5] = 16'h0002;
         for (i = 0; i < 6; i = i + 1)
            u_rfc_host_mem.mem[17'h10080 + i] = ex[i];
         run_cmd(18'h00040, 16'h0009, 16'h0100, 16'hA502, 16'h0);
         chk(txRingBase, 18'h12344);
         chk(txEntryWords, 8'h06);
         chk(txEntryCount, 16'h0010);
         chk(rxRingBase, 18'h30AB0);
         chk(rxEntryWords, 8'h08);
         chk(rxEntryCount, 16'h0002);
         run_cmd(18'h00040, 16'h0008, 16'h0200, 16'h0, 16'h0);
         chk_list(18'h00200, 6, -1);
         chk(u_rfc_host_mem.mem[17'h00020], 16'h0008);
      end
   endtask
   task t_bad;
      begin
         lat = 4'h1;
         run_cmd(18'h00040, 16'h0109, 16'h0300, 16'h0, 16'h0);
         reg_rd(`RFC_REG_CTRL);
         chk(d, 16'h0902);
         chk(txEntryWords, 8'h06);
         reg_rd(`RFC_REG_BASE_LO);
         chk(d, 16'h0040);
         reg_rd(2'h3);
         chk(d, 16'h0000);
      end
   endtask
   // Babble and multicast bytes are driven past their maxima on purpose
   task t_counters;
      begin
         lat = 4'h0;
         for (i = 0; i < 65541; i = i + 1) begin
            ev <= {i < 65540, i < 65540, i < 2, i < 5, i < 2, i < 2, i < 4,
                   i < 1, i < 2, i < 3};
            txAbortCause <= (i == 0) ? 6'h01 : 6'h24;
            @(posedge ref_clk);
         end
         for (i = 0; i < 55; i = i + 1)
            ex[i] = 16'h0000;
         ex[0] = 16'h0037;
         ex[2] = 16'h0003;
         ex[4] = 16'h0002;
         ex[20] = 16'h0001;
         ex[22] = 16'h0004;
         ex[24] = 16'hFFFE;
         ex[25] = 16'h0001;
         ex[26] = 16'hFFFF;
         ex[27] = 16'hFFFF;
         ex[28] = 16'h0025;
         ex[29] = 16'h0002;
         ex[30] = 16'h0005;
         ex[32] = 16'h0003;
         ex[33] = 16'hFFFF;
         run_cmd(18'h00040, 16'h000B, 16'h1000, 16'h0, 16'h006E);
         chk_list(18'h01000, 55, 1);
         // Roughly 65700 cycles at 20 cycles a second have passed
         chk(u_rfc_host_mem.mem[17'h00801] > 16'h0C00, 1'b1);
         chk(u_rfc_host_mem.mem[17'h00801] < 16'h0D00, 1'b1);
         for (i = 1; i < 55; i = i + 1)
            ex[i] = 16'h0000;
         run_cmd(18'h00040, 16'h000A, 16'h2000, 16'h0, 16'h006E);
         chk_list(18'h02000, 55, 1);
         chk(u_rfc_host_mem.mem[17'h01001] < 16'h0008, 1'b1);
         for (i = 0; i < 6; i = i + 1)
            u_rfc_host_mem.mem[17'h01800 + i] = 16'hBEEF;
         ex[0] = 16'h0004;
         run_cmd(18'h00040, 16'h000A, 16'h3000, 16'h0, 16'h0008);
         chk_list(18'h03000, 4, 1);
         chk(u_rfc_host_mem.mem[17'h01804], 16'hBEEF);
      end
   endtask

   initial begin
      failures = 0;
      n_checks = 0;
      rst = 1'b1;
      regAddr = 2'h0;
      regWdata = 16'h0000;
      regWe = 1'b0;
      regRe = 1'b0;
      ev = 10'h000;
      txByteCount = 16'hFFFF;
      txAbortCause = 6'h00;
      lat = 4'h0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_ring;
      t_bad;
      t_counters;
      wrap_up;
   end
endmodule // testbench
